// ==== inc/flash_spm_pkg.sv ====
/*
 Constants for the flash self-programming sequencer: control codes, section
 boundaries, loader sizes and operation timing.
 Assumes a 20 MHz system clock; the core drives the command port directly.
*/
package flash_spm_pkg;
	localparam int          CLK_HZ          = 20_000_000;
	localparam int          ARM_WINDOW      = 4;
	// control register codes; bit 7 of lock code is don't-care
	localparam logic [7:0]  CODE_LOAD       = 8'h01;
	localparam logic [7:0]  CODE_ERASE      = 8'h03;
	localparam logic [7:0]  CODE_WRITE      = 8'h05;
	localparam logic [6:0]  CODE_LOCK       = 7'h09;
	localparam logic [7:0]  CODE_REREAD     = 8'h11;
	localparam logic [11:0] RESET_APP_WORD  = 12'h000;
	localparam logic [11:0] HALT_SECT_START = 12'hC00;
	localparam logic [11:0] LOADER_START_00 = 12'hC00;
	localparam logic [11:0] LOADER_START_01 = 12'hE00;
	localparam logic [11:0] LOADER_START_10 = 12'hF00;
	localparam logic [11:0] LOADER_START_11 = 12'hF80;
	// 4.1 ms nominal sits inside the 3.7 to 4.5 ms band
	localparam int          OP_TIME_US      = 4100;
	localparam int          OP_CYCLES       = OP_TIME_US * (CLK_HZ / 1_000_000);
	typedef enum logic [1:0] {IDLE, ARMED, BUSY} seq_state_t;
	typedef enum logic [1:0] {OP_ERASE, OP_WRITE, OP_LOCK} op_kind_t;
endpackage

// ==== rtl/flash_spm_seq.sv ====
/*
 Flash self-programming sequencer: command arming, page buffer, erase/write/lock
 timing, section decode, halt and busy reporting, reset vector select.
 Assumes the core presents one-cycle write and store strobes on sys_clk, and the
 flash array accepts erase/program requests with a page image.
*/
module flash_spm_seq #(
	parameter int PAGE_WORDS = 32,
	parameter int PAGE_BITS  = 7,
	parameter int OP_CYCLES  = flash_spm_pkg::OP_CYCLES
) (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	// fuses
	input  wire logic                  boot_vector_fuse,
	input  wire logic                  loader_size_fuse_hi,
	input  wire logic                  loader_size_fuse_lo,
	// core command port
	input  wire logic                  ctrlWrite,
	input  wire logic [7:0]            ctrlData,
	input  wire logic                  storeStrobe,
	input  wire logic [15:0]           zPointer,
	input  wire logic [15:0]           dataR1R0,
	input  wire logic [11:0]           execWordAddr,
	input  wire logic                  eepromWrite,
	// program memory load port
	input  wire logic [15:0]           loadByteAddr,
	input  wire logic [15:0]           flashWordIn,
	output logic      [11:0]           flashReadWord,
	output logic      [7:0]            loadByte,
	// status and control out
	output logic      [7:0]            progCtrlRead,
	output logic                       coreHalt,
	output logic                       section_busy_flag,
	output logic      [11:0]           resetVector,
	output logic      [11:0]           loaderStart,
	// flash array
	output logic                       arrayErase,
	output logic                       arrayProgram,
	output logic                       arrayLock,
	output logic      [PAGE_BITS-1:0]  arrayPage,
	output logic      [7:0]            arrayLockData,
	output logic      [PAGE_WORDS*16-1:0] arrayImage
);
	localparam int WB = $clog2(PAGE_WORDS);

	typedef struct packed {
		flash_spm_pkg::seq_state_t state;
		flash_spm_pkg::op_kind_t   op;
		logic [7:0]                ctrl;
		logic [2:0]                armCnt;
		logic [31:0]               opCnt;
		logic [PAGE_BITS-1:0]      page;
		logic [7:0]                lockData;
		logic                      busy;
		logic                      halt;
		logic [PAGE_WORDS-1:0]     filled;
		logic [PAGE_WORDS*16-1:0]  buffer;
		logic [7:0]                loadByte;
	} seq_regs_t;

	seq_regs_t s_r;
	seq_regs_t s_nxt;

	logic [WB-1:0]        wordIdx;
	logic [PAGE_BITS-1:0] pageIdx;
	logic                 fromLoader;
	logic                 bufClear;

	function automatic logic inHalting(input logic [PAGE_BITS-1:0] pg);
		logic [11:0] w;
		w = 12'(pg) << WB;
		return w >= flash_spm_pkg::HALT_SECT_START;
	endfunction

	always_comb begin
		case ({loader_size_fuse_hi, loader_size_fuse_lo})
			2'b00:   loaderStart = flash_spm_pkg::LOADER_START_00;
			2'b01:   loaderStart = flash_spm_pkg::LOADER_START_01;
			2'b10:   loaderStart = flash_spm_pkg::LOADER_START_10;
			default: loaderStart = flash_spm_pkg::LOADER_START_11;
		endcase
	end

	// fuses are inputs only; nothing here can write them
	assign resetVector = boot_vector_fuse ? flash_spm_pkg::RESET_APP_WORD
	                                      : loaderStart;

	assign wordIdx    = zPointer[WB:1];
	assign pageIdx    = zPointer[PAGE_BITS+WB:WB+1];
	assign fromLoader = execWordAddr >= loaderStart;
	assign flashReadWord = loadByteAddr[12:1];

	always_comb begin
		s_nxt    = s_r;
		bufClear = 1'b0;
		s_nxt.loadByte = loadByteAddr[0] ? flashWordIn[15:8] : flashWordIn[7:0];
		case (s_r.state)
			flash_spm_pkg::IDLE: begin
				if (ctrlWrite && ctrlData[0]) begin
					s_nxt.state  = flash_spm_pkg::ARMED;
					s_nxt.ctrl   = ctrlData;
					s_nxt.armCnt = 3'(flash_spm_pkg::ARM_WINDOW);
				end
			end
			flash_spm_pkg::ARMED: begin
				if (storeStrobe && fromLoader) begin
					s_nxt.state = flash_spm_pkg::IDLE;
					s_nxt.ctrl  = 8'h00;
					if (s_r.ctrl == flash_spm_pkg::CODE_LOAD) begin
						s_nxt.busy = 1'b0;
						// second load to a slot is refused
						if (!s_r.filled[wordIdx]) begin
							s_nxt.filled[wordIdx] = 1'b1;
							s_nxt.buffer[wordIdx*16 +: 16] = dataR1R0;
						end
					end else if (s_r.ctrl == flash_spm_pkg::CODE_REREAD) begin
						s_nxt.busy = 1'b0;
						bufClear   = 1'b1;
					end else if (s_r.ctrl == flash_spm_pkg::CODE_ERASE ||
					             s_r.ctrl == flash_spm_pkg::CODE_WRITE) begin
						s_nxt.state = flash_spm_pkg::BUSY;
						s_nxt.op    = (s_r.ctrl == flash_spm_pkg::CODE_ERASE) ?
						              flash_spm_pkg::OP_ERASE : flash_spm_pkg::OP_WRITE;
						s_nxt.page  = pageIdx;
						s_nxt.opCnt = 32'(OP_CYCLES);
						s_nxt.halt  = inHalting(pageIdx);
						if (!inHalting(pageIdx))
							s_nxt.busy = 1'b1;
					end else if (s_r.ctrl[6:0] == flash_spm_pkg::CODE_LOCK) begin
						// pointer ignored, no halt
						s_nxt.state    = flash_spm_pkg::BUSY;
						s_nxt.op       = flash_spm_pkg::OP_LOCK;
						s_nxt.lockData = dataR1R0[7:0];
						s_nxt.opCnt    = 32'(OP_CYCLES);
					end
				end else if (s_r.armCnt == 3'h1) begin
					s_nxt.state = flash_spm_pkg::IDLE;
					s_nxt.ctrl  = 8'h00;
				end else begin
					s_nxt.armCnt = s_r.armCnt - 3'h1;
				end
			end
			flash_spm_pkg::BUSY: begin
				if (s_r.opCnt == 32'h1) begin
					s_nxt.state = flash_spm_pkg::IDLE;
					s_nxt.halt  = 1'b0;
					s_nxt.ctrl  = 8'h00;
					if (s_r.op == flash_spm_pkg::OP_WRITE)
						bufClear = 1'b1;
				end else begin
					s_nxt.opCnt = s_r.opCnt - 32'h1;
				end
			end
			default: s_nxt.state = flash_spm_pkg::IDLE;
		endcase
		// eeprom write loses any loaded words
		if (bufClear || eepromWrite) begin
			s_nxt.filled = '0;
			s_nxt.buffer = '1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_r        <= '0;
			s_r.state  <= flash_spm_pkg::IDLE;
			s_r.buffer <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// array strobes pulse at the first busy cycle; flash holds page for the op
	assign arrayErase   = s_r.state == flash_spm_pkg::BUSY && s_r.op == flash_spm_pkg::OP_ERASE
	                      && s_r.opCnt == 32'(OP_CYCLES);
	assign arrayProgram = s_r.state == flash_spm_pkg::BUSY && s_r.op == flash_spm_pkg::OP_WRITE
	                      && s_r.opCnt == 32'(OP_CYCLES);
	assign arrayLock    = s_r.state == flash_spm_pkg::BUSY && s_r.op == flash_spm_pkg::OP_LOCK
	                      && s_r.opCnt == 32'(OP_CYCLES);
	assign arrayPage         = s_r.page;
	assign arrayLockData     = s_r.lockData;
	assign arrayImage        = s_r.buffer;
	assign coreHalt          = s_r.halt;
	assign section_busy_flag = s_r.busy;
	assign loadByte          = s_r.loadByte;
	assign progCtrlRead = {1'b0, s_r.busy, 5'(s_r.ctrl[5:1]),
	                       s_r.state != flash_spm_pkg::IDLE};
endmodule

// ==== bench/flash_spm_seq_assertions.sv ====
/*
 Concurrent checks on the flash self-programming sequencer ports.
 Assumes 32-word pages, 7-bit page index and a short operation count in sim.
*/
module flash_spm_seq_assertions (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        srst,
	// watched ports
	input wire logic        boot_vector_fuse, loader_size_fuse_hi, loader_size_fuse_lo,
	input wire logic        ctrlWrite, storeStrobe, coreHalt, section_busy_flag,
	input wire logic        arrayErase, arrayProgram, arrayLock,
	input wire logic [11:0] execWordAddr, flashReadWord, resetVector, loaderStart,
	input wire logic [15:0] loadByteAddr, flashWordIn,
	input wire logic [7:0]  loadByte,
	input wire logic [6:0]  arrayPage
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	vec_sel_a: assert property (resetVector == (boot_vector_fuse ? 12'h000 : loaderStart))
		else $error("reset vector wrong");
	size_sel_a: assert property (loaderStart == (loader_size_fuse_hi ?
		(loader_size_fuse_lo ? 12'hF80 : 12'hF00) : (loader_size_fuse_lo ? 12'hE00 : 12'hC00)))
		else $error("loader start wrong");
	erase_pulse_a: assert property (arrayErase |=> !arrayErase)
		else $error("erase pulse long");
	halt_erase_a: assert property ((arrayErase || arrayProgram) && arrayPage >= 7'd96
		|-> coreHalt) else $error("no halt");
	rww_busy_a: assert property ((arrayErase || arrayProgram) && arrayPage < 7'd96
		|-> !coreHalt && section_busy_flag) else $error("busy or halt wrong");
	lock_run_a: assert property (arrayLock |-> !coreHalt ##1 !coreHalt)
		else $error("lock halts");
	unarmed_store_a: assert property (storeStrobe && !$past(ctrlWrite)
		&& !$past(ctrlWrite, 2) && !$past(ctrlWrite, 3) && !$past(ctrlWrite, 4)
		|=> !(arrayErase || arrayProgram || arrayLock)) else $error("unarmed store acted");
	app_store_a: assert property (storeStrobe && execWordAddr < loaderStart
		|=> !(arrayErase || arrayProgram || arrayLock)) else $error("app store acted");
	byte_sel_a: assert property (!$past(srst) |-> loadByte == ($past(loadByteAddr[0]) ?
		$past(flashWordIn[15:8]) : $past(flashWordIn[7:0]))) else $error("byte select wrong");
	word_addr_a: assert property (flashReadWord == loadByteAddr[12:1])
		else $error("load addr");
	halt_time_a: assert property ($rose(coreHalt) |-> coreHalt[*8])
		else $error("halt short");
endmodule

// ==== bench/core_model.sv ====
/*
 Core model: arms a control code and issues the store instruction.
 Assumes inputs are sampled on the rising edge; drives on the falling edge.
*/
module core_model (
	// clock
	input wire logic        sys_clk,
	// command side
	output logic            ctrlWrite, storeStrobe, eepromWrite,
	output logic [7:0]      ctrlData,
	output logic [15:0]     zPointer, dataR1R0,
	output logic [11:0]     execWordAddr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{ctrlWrite, storeStrobe, eepromWrite, ctrlData, zPointer, dataR1R0} = '0;
		execWordAddr = 12'hFC0;
	end
	// gap 1..4 lands in the arming window, 5 misses it
	task automatic spm(input logic [7:0] c, input logic [15:0] z, d, input int gap);
		@(negedge sys_clk);
		{ctrlWrite, ctrlData, zPointer, dataR1R0} = {1'b1, c, z, d};
		@(negedge sys_clk);
		ctrlWrite = 0;
		repeat (gap - 1) @(negedge sys_clk);
		storeStrobe = 1;
		@(negedge sys_clk);
		storeStrobe = 0;
		// released operands no longer hold their value
		zPointer = ~z;
		dataR1R0 = ~d;
	endtask
	task automatic eep();
		@(negedge sys_clk) eepromWrite = 1;
		@(negedge sys_clk) eepromWrite = 0;
	endtask
endmodule

// ==== bench/tb_flash_spm_seq.sv ====
/*
 Self-checking bench for the flash self-programming sequencer.
 Assumes the core model drives the command port; operation count shortened.
*/
module tb_flash_spm_seq;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OPC = 10;
	logic sys_clk = 0, srst = 1, boot_vector_fuse = 1, loader_size_fuse_hi = 1;
	logic loader_size_fuse_lo = 1, ctrlWrite, storeStrobe, eepromWrite, coreHalt;
	logic section_busy_flag, arrayErase, arrayProgram, arrayLock;
	logic [15:0] loadByteAddr = 16'h0003, flashWordIn = 16'hA55A, zPointer, dataR1R0;
	logic [7:0] ctrlData, loadByte, progCtrlRead, arrayLockData;
	logic [11:0] execWordAddr, flashReadWord, resetVector, loaderStart;
	logic [6:0] arrayPage;
	logic [511:0] arrayImage;
	logic [11:0] ls [4] = '{12'hC00, 12'hE00, 12'hF00, 12'hF80};
	int err_total = 0, tests_run = 0, cyc = 0;
	always #25 sys_clk = ~sys_clk;
	flash_spm_seq #(.OP_CYCLES(OPC)) DUT (.sys_clk, .srst, .boot_vector_fuse,
		.loader_size_fuse_hi, .loader_size_fuse_lo, .ctrlWrite, .ctrlData, .storeStrobe,
		.zPointer, .dataR1R0, .execWordAddr, .eepromWrite, .loadByteAddr, .flashWordIn,
		.flashReadWord, .loadByte, .progCtrlRead, .coreHalt, .section_busy_flag, .resetVector,
		.loaderStart, .arrayErase, .arrayProgram, .arrayLock, .arrayPage, .arrayLockData, .arrayImage);
	core_model core (.sys_clk, .ctrlWrite, .storeStrobe, .eepromWrite, .ctrlData, .zPointer,
		.dataR1R0, .execWordAddr);
	task automatic chk(input logic [15:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic [2:0] exp, input logic [6:0] pg);
		logic [2:0] k;
		// the array pulse already stands when the store call returns
		k = {arrayLock, arrayProgram, arrayErase};
		for (int i = 0; i < 4 && k == 0; i++) begin
			@(negedge sys_clk);
			k = {arrayLock, arrayProgram, arrayErase};
		end
		chk(k, exp);
		if (exp[1:0] != 0) chk(arrayPage, pg);
	endtask
	task automatic fin();
		repeat (OPC + 4) @(negedge sys_clk);
		chk({coreHalt, progCtrlRead[0]}, 0);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ceiling well above the roughly 150 cycles the tests need
	always @(posedge sys_clk) if (++cyc == 20000) begin
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (6) @(negedge sys_clk);
		srst = 0;
		for (int f = 0; f < 8; f++) begin
			{boot_vector_fuse, loader_size_fuse_hi, loader_size_fuse_lo} = f[2:0];
			#1 chk(loaderStart, ls[f % 4]);
			chk(resetVector, f[2] ? 12'h000 : ls[f % 4]);
		end
		@(negedge sys_clk);
		chk(flashReadWord, 12'h001);
		chk(loadByte, 8'hA5);
		$display("fuse test done");
		core.spm(8'h01, 16'h3906, 16'h1234, 1);
		core.spm(8'h01, 16'h1902, 16'h5678, 3);
		core.spm(8'h01, 16'h1906, 16'hBEEF, 4);
		core.spm(8'h03, 16'h1900, 16'h0000, 2);
		op(3'b001, 7'd100);
		chk(coreHalt, 1);
		fin();
		core.spm(8'h05, 16'h1900, 16'h0000, 2);
		op(3'b010, 7'd100);
		chk(arrayImage[63:48], 16'h1234);
		chk(arrayImage[31:16], 16'h5678);
		chk(arrayImage[15:0], 16'hFFFF);
		chk(coreHalt, 1);
		fin();
		core.spm(8'h05, 16'h0140, 16'h0000, 1);
		op(3'b010, 7'd5);
		chk(arrayImage[63:48], 16'hFFFF);
		fin();
		chk(section_busy_flag, 1);
		core.spm(8'h01, 16'h0142, 16'h0BAD, 1);
		chk(section_busy_flag, 0);
		core.eep();
		core.spm(8'h05, 16'h0140, 16'h0000, 1);
		op(3'b010, 7'd5);
		chk(arrayImage[31:16], 16'hFFFF);
		fin();
		$display("buffer test done");
		core.spm(8'h03, 16'h0140, 16'h0000, 5);
		op(3'b000, 7'd0);
		core.execWordAddr = 12'h100;
		core.spm(8'h03, 16'h0140, 16'h0000, 1);
		op(3'b000, 7'd0);
		core.execWordAddr = 12'hFC0;
		core.spm(8'h89, 16'h0001, 16'h00F0, 3);
		op(3'b100, 7'd0);
		chk(arrayLockData, 8'hF0);
		chk(coreHalt, 0);
		fin();
		core.spm(8'h03, 16'h17C0, 16'h0000, 4);
		op(3'b001, 7'd95);
		chk(coreHalt, 0);
		fin();
		$display("command test done");
		end_of_test();
	end
endmodule
bind flash_spm_seq flash_spm_seq_assertions chk_i (.sys_clk, .srst, .boot_vector_fuse,
	.loader_size_fuse_hi, .loader_size_fuse_lo, .ctrlWrite, .storeStrobe, .coreHalt,
	.section_busy_flag, .arrayErase, .arrayProgram, .arrayLock, .execWordAddr, .flashReadWord,
	.resetVector, .loaderStart, .loadByteAddr, .flashWordIn, .loadByte, .arrayPage);
